// File: sar_ctrl_pkg.sv
// Purpose: Shared constants and types for the converter control block.
// Assumes: 100 MHz mclk, 12-bit result.
// Notes:   Hold and setup counts are derived from a time in ns; edge and strap counts are fixed.
package sar_ctrl_pkg;

   // ----------------------------------------
   // Widths and reset values
   // ----------------------------------------
   localparam int               RESULT_W   = 12;
   localparam logic [11:0]      RESULT_RST = 12'h000;
   localparam logic [11:0]      MSB_TRIAL  = 12'h800;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int               CLK_PERIOD_NS  = 10;
   localparam int               HOLD_DELAY_NS  = 10;
   localparam logic [3:0]       HOLD_DELAY_CYC =
      4'((HOLD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int               SETUP_NS       = 50;
   localparam logic [3:0]       SETUP_CYC      =
      4'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0]       CONV_EDGES     = 4'hd;
   localparam logic [1:0]       CONT_ACQ_EDGES = 2'h2;
   localparam logic [1:0]       STRAP_SETTLE   = 2'h3;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_ACQ  = 3'h2,
      ST_CONV = 3'h4
   } state_e;

   typedef struct packed {
      logic convert_start_n;
      logic read_n;
      logic chip_sel_n;
   } strobes_s;

endpackage

// File: sar_adc_conversion_control.sv
// Purpose: Conversion control, approximation register and bus side of a 12-bit SAR converter.
// Assumes: All pins are asynchronous to mclk and pass two flip-flops.
// Notes:   Approximation steps happen on rising conversion clock edges only.
//
// Operation
// - Each result appears as a 12-bit word on three-state data lines.
// - Results are coded in two's complement.
// - Track/hold tracks when idle, holds about 10ns after start.
// - Unsynchronised starts give conversions of 13 or 14 clock cycles.
// - Approximation register changes only on conversion clock rising edges.
// - Start 50ns before edge gives 13; within 10ns gives 14.
// - A conversion begins only while convert start is low.
// - Start requests during a conversion are ignored.
// - Data lines are driven only while read and chip select are low.
// - Mode strap high selects interrupt, otherwise busy status.
// - Interrupt status falls at completion, rises once result is read.
// - Busy status low from start until result is on the lines.
// - Convert start falling edge holds the input and starts approximation.
// - All three strobes low reads old result and starts anew.
// - With convert start and read low, select falling starts conversion.
// - Continuous mode converts every 14 clocks, two for acquisition.
// - Most significant bit on the top data line, least on line zero.
`timescale 1ns/1ns
module sar_adc_conversion_control
   import sar_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic                mclk,
   input  wire logic                rst,
   // Bus strobes, active low
   input  wire strobes_s            strobes,
   // Conversion clock pin
   input  wire logic                conversion_clock_in,
   // Analog comparator decision, high when trial exceeds input
   input  wire logic                comparator_high,
   // Mode strap, decoded pin level
   input  wire logic                mode_tied_high,
   input  wire logic                mode_tied_low,
   // Data lines, three-state as value plus enable
   output logic [RESULT_W-1:0]      result_lines,
   output logic                     result_oe,
   // Status and track/hold control
   output logic                     status_n,
   output logic                     track_hold
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   state_e      state;
   state_e      next_state;
   logic [6:0]  sync_a;
   logic [6:0]  sync_b;
   strobes_s    strb;
   strobes_s    strb_prev;
   logic        clk_prev;
   logic [3:0]  edge_cnt;
   logic [3:0]  setup_cnt;
   logic [3:0]  hold_cnt;
   logic [1:0]  acq_cnt;
   logic [1:0]  strap_cnt;
   logic        strap_taken;
   logic        int_mode;
   logic        cont_mode;
   logic        first_seen;
   logic [11:0] sar;
   logic [11:0] mask;
   logic [3:0]  raw_edges;

   // Offset binary from the register, sign bit inverted
   function automatic logic [11:0] to_twos(input logic [11:0] v);
      to_twos = {~v[11], v[10:0]};
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Two stages; only sync_b is read by logic, edge history rides along
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sync_a    <= 7'h07;
         sync_b    <= 7'h07;
         strb_prev <= 3'h7;
         clk_prev  <= 1'b0;
      end else begin
         sync_a    <= {mode_tied_high, mode_tied_low, comparator_high,
                       conversion_clock_in, strobes};
         sync_b    <= sync_a;
         strb_prev <= strb;
         clk_prev  <= sync_b[3];
      end
   end

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire  rd_sel      = ~strb.read_n & ~strb.chip_sel_n;
   wire  rd_sel_prev = ~strb_prev.read_n & ~strb_prev.chip_sel_n;
   wire  conv_low    = ~strb.convert_start_n;
   wire  conv_fall   = conv_low & strb_prev.convert_start_n;
   wire  sel_fall    = conv_low & rd_sel & ~rd_sel_prev;
   wire  all_low     = conv_low & rd_sel;
   wire  cont_go     = cont_mode & all_low;
   wire  in_conv     = (state == ST_CONV);
   // Only an idle converter accepts a start, and only with start low
   wire  start_trig  = (state == ST_IDLE) & (conv_fall | sel_fall);
   // Conversion clock edge becomes a one-cycle enable
   wire  clk_rise    = sync_b[3] & ~clk_prev;
   wire  comp_hi     = sync_b[4];
   wire  setup_ok    = (setup_cnt >= SETUP_CYC);
   // A first edge too close to the start is skipped
   wire  count_edge  = in_conv & clk_rise & (first_seen | setup_ok);
   wire  last_edge   = (edge_cnt == 4'(CONV_EDGES - 4'h1));
   wire  conv_done   = count_edge & last_edge;
   wire  acq_last    = (state == ST_ACQ) & clk_rise &
                       (acq_cnt == 2'(CONT_ACQ_EDGES - 2'h1));
   wire [11:0] sar_dec = comp_hi ? (sar & ~mask) : sar;
   assign strb = strobes_s'(sync_b[2:0]);

   // ----------------------------------------
   // Mode strap
   // ----------------------------------------
   // Strap is sampled after reset release once the synchroniser has settled
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         strap_cnt   <= 2'h0;
         strap_taken <= 1'b0;
         int_mode    <= 1'b0;
         cont_mode   <= 1'b0;
      end else if (!strap_taken) begin
         int_mode  <= sync_b[6];
         cont_mode <= ~sync_b[6] & sync_b[5];
         strap_cnt <= 2'(strap_cnt + 2'h1);
         if (strap_cnt == STRAP_SETTLE) begin
            strap_taken <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (start_trig) begin
               next_state = ST_CONV;
            end
         end
         ST_CONV: begin
            if (conv_done) begin
               next_state = cont_go ? ST_ACQ : ST_IDLE;
            end
         end
         ST_ACQ: begin
            if (!cont_go) begin
               next_state = ST_IDLE;
            end else if (acq_last) begin
               next_state = ST_CONV;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------
   // Approximation register
   // ----------------------------------------
   // Restart in continuous mode lands on an edge, so that edge is step one
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         edge_cnt   <= 4'h0;
         setup_cnt  <= 4'h0;
         first_seen <= 1'b0;
         sar        <= RESULT_RST;
         mask       <= RESULT_RST;
      end else if (start_trig) begin
         edge_cnt   <= 4'h0;
         setup_cnt  <= 4'h0;
         first_seen <= 1'b0;
      end else if (acq_last) begin
         edge_cnt   <= 4'h1;
         first_seen <= 1'b1;
         sar        <= MSB_TRIAL;
         mask       <= MSB_TRIAL;
      end else if (in_conv) begin
         if (!first_seen && !setup_ok) begin
            setup_cnt <= 4'(setup_cnt + 4'h1);
         end
         if (clk_rise) begin
            first_seen <= 1'b1;
         end
         if (count_edge) begin
            edge_cnt <= 4'(edge_cnt + 4'h1);
            if (edge_cnt == 4'h0) begin
               sar  <= MSB_TRIAL;
               mask <= MSB_TRIAL;
            end else begin
               sar  <= sar_dec | (mask >> 1);
               mask <= mask >> 1;
            end
         end
      end
   end
   // Acquisition edge count between continuous conversions
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         acq_cnt <= 2'h0;
      end else if (state != ST_ACQ) begin
         acq_cnt <= 2'h0;
      end else if (clk_rise) begin
         acq_cnt <= 2'(acq_cnt + 2'h1);
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Latch changes only at completion, so a joint read sees the old word
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         result_lines <= RESULT_RST;
      end else if (conv_done) begin
         result_lines <= to_twos(sar_dec);
      end
   end
   // Drive enable follows read and select together
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         result_oe <= 1'b0;
      end else begin
         result_oe <= rd_sel;
      end
   end
   // Hold after the set delay; tracking whenever idle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         hold_cnt   <= 4'h0;
         track_hold <= 1'b0;
      end else if (!in_conv) begin
         hold_cnt   <= 4'h0;
         track_hold <= 1'b0;
      end else if (hold_cnt >= 4'(HOLD_DELAY_CYC - 4'h1)) begin
         track_hold <= 1'b1;
      end else begin
         hold_cnt <= 4'(hold_cnt + 4'h1);
      end
   end
   // Status: completion wins over a read in the same cycle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         status_n <= 1'b1;
      end else if (int_mode) begin
         if (conv_done) begin
            status_n <= 1'b0;
         end else if (rd_sel) begin
            status_n <= 1'b1;
         end
      end else if (start_trig || acq_last) begin
         status_n <= 1'b0;
      end else if (conv_done) begin
         status_n <= 1'b1;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Raw conversion clock edges since start, skipped ones included
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         raw_edges <= 4'h0;
      end else if (start_trig) begin
         raw_edges <= 4'h0;
      end else if (acq_last) begin
         raw_edges <= 4'h1;
      end else if (in_conv && clk_rise) begin
         raw_edges <= 4'(raw_edges + 4'h1);
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_read_taken;
      int_mode && rd_sel && !conv_done;
   endsequence
   sequence s_first_edge;
      in_conv && clk_rise && !first_seen;
   endsequence

   chk_oe_select: assert property (rd_sel |=> result_oe) else $error("data lines not enabled on read");
   chk_oe_release: assert property (!rd_sel |=> !result_oe) else $error("data lines driven without read");
   chk_start_low: assert property ($rose(in_conv) && $past(state) == ST_IDLE |-> $past(conv_low))
      else $error("conversion began with start high");
   chk_no_restart: assert property (in_conv && !conv_done |=> in_conv && edge_cnt >= $past(edge_cnt))
      else $error("running conversion restarted");
   chk_edge_total: assert property (conv_done |-> raw_edges == 4'hc || raw_edges == 4'hd)
      else $error("conversion length not 13 or 14 clocks");
   chk_setup_early: assert property (s_first_edge and setup_ok |=> edge_cnt == 4'h1)
      else $error("early start did not count first edge");
   chk_setup_late: assert property (s_first_edge and !setup_ok |=> edge_cnt == 4'h0)
      else $error("late start counted first edge");
   chk_sar_edge: assert property (in_conv && !clk_rise |=> $stable(edge_cnt) && $stable(sar))
      else $error("register changed off a clock edge");
   chk_hold_on: assert property ($rose(in_conv) |=> track_hold)
      else $error("track/hold not holding after start");
   chk_hold_off: assert property (!in_conv |=> !track_hold) else $error("track/hold not tracking when idle");
   chk_int_fall: assert property (int_mode && conv_done |=> !status_n)
      else $error("interrupt did not fall at completion");
   chk_int_clear: assert property (s_read_taken |=> status_n) else $error("interrupt not cleared by read");
   chk_busy_low: assert property (!int_mode && in_conv |-> !status_n)
      else $error("busy high during conversion");
   chk_busy_data: assert property (!int_mode && conv_done |=> status_n && result_lines == to_twos($past(sar_dec)))
      else $error("busy released without new data");
   chk_result_held: assert property (!conv_done |=> $stable(result_lines))
      else $error("result latch changed before completion");
   chk_cont_acq: assert property (conv_done && cont_go |=> state == ST_ACQ ##0 (state == ST_ACQ)[*1])
      else $error("continuous mode skipped acquisition");

endmodule

// File: sar_front_model.sv
// Purpose: Analog front end and conversion clock source facing the block.
// Assumes: mclk at 100 MHz; comparator held at one level per conversion.
// Notes:   A fixed level yields only full-scale codes, so no trial tracking.
`timescale 1ns/1ns
module sar_front_model (
   // Clock
   input  wire logic mclk,
   // Sample level, high means input below every trial value
   input  wire logic level,
   // Track/hold state from the block
   input  wire logic track_hold,
   // Far-side pins
   output logic      conversion_clock_in,
   output logic      comparator_high
);
   // ----------------------------------------
   // Clock divider and comparator
   // ----------------------------------------
   int unsigned div  = 0;
   logic        junk = 1'b0;

   // 5 MHz keeps inside both the normal and continuous clock limits
   always @(posedge mclk) begin
      div  <= (div == 19) ? 0 : div + 1;
      junk <= ~junk;
   end

   assign conversion_clock_in = (div >= 10);
   // While tracking the decision means nothing, so it wanders
   assign comparator_high     = track_hold ? level : junk;
endmodule

// File: test_sar_adc_conversion_control.sv
// Purpose: Self-checking bench for the converter control block.
// Assumes: 100 MHz mclk; front end model runs a 5 MHz conversion clock.
// Notes:   Reads are noted in a queue and compared when the drivers enable.
`timescale 1ns/1ns
module test_sar_adc_conversion_control;
   import sar_ctrl_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic                mclk           = 1'b0;
   logic                rst            = 1'b1;
   strobes_s            strobes        = '1;
   logic                mode_tied_high = 1'b0;
   logic                mode_tied_low  = 1'b0;
   logic                level          = 1'b0;
   logic                oe_q           = 1'b0;
   logic                conversion_clock_in;
   logic                comparator_high;
   logic [RESULT_W-1:0] result_lines;
   logic                result_oe;
   logic                status_n;
   logic                track_hold;
   logic [11:0]         exp_q[$];
   int                  miscompares    = 0;
   int                  checks_done    = 0;
   int                  cc             = 0;
   int                  mcnt           = 0;
   int                  seed           = 68;

   sar_adc_conversion_control sar_adc_conversion_control_i (
      .mclk(mclk), .rst(rst), .strobes(strobes),
      .conversion_clock_in(conversion_clock_in), .comparator_high(comparator_high),
      .mode_tied_high(mode_tied_high), .mode_tied_low(mode_tied_low),
      .result_lines(result_lines), .result_oe(result_oe),
      .status_n(status_n), .track_hold(track_hold));

   sar_front_model sar_front_model_i (
      .mclk(mclk), .level(level), .track_hold(track_hold),
      .conversion_clock_in(conversion_clock_in), .comparator_high(comparator_high));

   // ----------------------------------------
   // Clock, counters and read monitor
   // ----------------------------------------
   always #5 mclk = ~mclk;
   always @(posedge conversion_clock_in) cc++;
   always @(posedge mclk) mcnt++;

   // Oldest note is compared when the data lines start driving
   always @(posedge mclk) begin
      oe_q <= result_oe;
      if (result_oe === 1'b1 && oe_q !== 1'b1) begin
         check("result_lines", result_lines, exp_q.size() ? exp_q.pop_front() : 12'hxxx);
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic final_report();
      if (miscompares == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Inputs move 1 ns after the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // Bounded wait for a status level; running out ends the run
   task automatic wait_st(input logic lvl, input int bound);
      int i;
      for (i = 0; i < bound && status_n !== lvl; i++) cyc(1);
      if (i == bound) begin
         check("status wait", 12'h0, 12'h1);
         final_report();
      end
   endtask

   task automatic do_reset(input logic hi, input logic lo);
      rst            = 1'b1;
      mode_tied_high = hi;
      mode_tied_low  = lo;
      strobes        = '1;
      cyc(5);
      check("rst oe", 12'(result_oe), 12'h0);
      check("rst status", 12'(status_n), 12'h1);
      check("rst hold", 12'(track_hold), 12'h0);
      rst = 1'b0;
      cyc(6); // Strap settles first
   endtask

   // Start by convert strobe; early start is synchronised, late is 9 ns before an edge
   task automatic conv(input bit late, input bit bump, output logic [11:0] exp);
      int c0;
      level = 1'($random(seed));
      exp   = level ? 12'h800 : 12'h7ff;
      @(posedge conversion_clock_in);
      #1;
      if (late) cyc(19);
      c0                      = cc;
      strobes.convert_start_n = 1'b0;
      cyc(4);
      check("status start", 12'(status_n), 12'(mode_tied_high));
      check("hold", 12'(track_hold), 12'h1);
      if (bump) begin
         strobes.convert_start_n = 1'b1;
         cyc(3);
         strobes.convert_start_n = 1'b0;
      end
      wait_st(~mode_tied_high, 600);
      check("edges", 12'(cc - c0), late ? 12'd14 : 12'd13);
      cyc(2);
      check("track", 12'(track_hold), 12'h0);
   endtask

   task automatic rd(input logic [11:0] exp);
      exp_q.push_back(exp);
      strobes = '{strobes.convert_start_n, 1'b0, 1'b0};
      cyc(6);
      strobes = '1;
      cyc(6);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [11:0] a;
      logic [11:0] b;
      int          t;
      do_reset(1'b0, 1'b0);
      // Power-up: 14 conversion clocks plus acquisition before first start
      cyc(320);
      // Read alone starts nothing and shows the reset latch
      exp_q.push_back(RESULT_RST);
      strobes = '{1'b1, 1'b0, 1'b0};
      cyc(10);
      check("no start", 12'(status_n), 12'h1);
      strobes = '1;
      cyc(40);
      conv(1'b0, 1'b1, a);
      strobes.convert_start_n = 1'b1;
      cyc(40);
      rd(a);
      // Half of the select pair never drives
      strobes.read_n = 1'b0;
      cyc(6);
      check("oe rd only", 12'(result_oe), 12'h0);
      strobes = '{1'b1, 1'b1, 1'b0};
      cyc(6);
      check("oe cs only", 12'(result_oe), 12'h0);
      strobes = '1;
      cyc(40);
      conv(1'b1, 1'b0, a);
      // Select falling last reads the old word and starts anew
      strobes.read_n = 1'b0;
      level          = ~level;
      b              = level ? 12'h800 : 12'h7ff;
      cyc(40);
      exp_q.push_back(a);
      strobes.chip_sel_n = 1'b0;
      cyc(4);
      check("cs start", 12'(status_n), 12'h0);
      cyc(100);
      check("latch held", result_lines, a);
      wait_st(1'b1, 600);
      strobes = '1;
      cyc(40);
      rd(b);
      // Interrupt strap
      do_reset(1'b1, 1'b0);
      conv(1'b0, 1'b0, a);
      strobes.convert_start_n = 1'b1;
      cyc(40);
      check("int held", 12'(status_n), 12'h0);
      rd(a);
      check("int cleared", 12'(status_n), 12'h1);
      // Continuous strap with all strobes low
      do_reset(1'b0, 1'b1);
      exp_q.push_back(RESULT_RST);
      strobes = '0;
      wait_st(1'b0, 50);
      wait_st(1'b1, 600);
      t = mcnt;
      wait_st(1'b0, 300);
      wait_st(1'b1, 600);
      check("period", 12'(mcnt - t), 12'd280);
      strobes.convert_start_n = 1'b1;
      cyc(600);
      check("stopped", 12'(status_n), 12'h1);
      final_report();
   end
endmodule
